//--- pkg/flash_seq_map.vh
`ifndef FLASH_SEQ_MAP_VH
`define FLASH_SEQ_MAP_VH
`define OP_READ_DUAL_OUT  8'h3B
`define OP_READ_DUAL_IO   8'hBB
`define OP_PAGE_PROGRAM   8'h02
`define OP_SECTOR_ERASE_A 8'h20
`define OP_SECTOR_ERASE_B 8'hD7
`define OP_BLOCK_ERASE    8'hD8
`define OP_CHIP_ERASE_A   8'h60
`define OP_CHIP_ERASE_B   8'hC7
`define OP_STATUS_READ    8'h05
`define OP_STATUS_WRITE   8'h01
`define OP_WRITE_ENABLE   8'h06
`define OP_WRITE_DISABLE  8'h04
`define ADDR_TOP          19'h7FFFF
`define STAT_BUSY_BIT     0
`define STAT_WEL_BIT      1
`define CLK_NS            50
`define PROGRAM_TIME_US   4000
`define SECTOR_ERASE_TIME_US 40000
`define BLOCK_ERASE_TIME_US  80000
`define ARRAY_ERASE_TIME_US  250000
`define US_TO_CYC(t)      ((t) * 1000 / `CLK_NS)
`endif

//--- verilog/flash_seq.v
`timescale 1ns/100ps
`include "flash_seq_map.vh"
module flash_seq
#(
  parameter PROGRAM_CYC = `US_TO_CYC(`PROGRAM_TIME_US),
  parameter SECTOR_CYC  = `US_TO_CYC(`SECTOR_ERASE_TIME_US),
  parameter BLOCK_CYC   = `US_TO_CYC(`BLOCK_ERASE_TIME_US),
  parameter ARRAY_CYC   = `US_TO_CYC(`ARRAY_ERASE_TIME_US)
)
(
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_nrst,
  // Serial link pins
  input  wire        i_cs_n,
  input  wire        i_sck,
  input  wire        i_data_line_lower,
  output reg         o_data_line_lower,
  output reg         o_data_line_lower_oe,
  input  wire        i_data_line_upper,
  output reg         o_data_line_upper,
  output reg         o_data_line_upper_oe,
  // Protection state
  input  wire        i_protect_hit,
  input  wire        i_any_protected,
  // Array read port
  output reg  [18:0] o_rd_addr,
  input  wire [7:0]  i_rd_data,
  // Array write port
  output reg         o_wr_en,
  output reg  [18:0] o_wr_addr,
  output reg  [7:0]  o_wr_data,
  // Erase request
  output reg         o_erase_en,
  output reg  [1:0]  o_erase_kind,
  output reg  [18:0] o_erase_addr,
  // Status
  output wire        o_busy,
  output wire        o_wel
);

localparam S_IDLE = 3'h0;
localparam S_CMD  = 3'h1;
localparam S_ADDR = 3'h2;
localparam S_DUMMY = 3'h3;
localparam S_RDATA = 3'h4;
localparam S_PDATA = 3'h5;
localparam S_STAT = 3'h6;
localparam S_SKIP = 3'h7;

localparam K_SECTOR = 2'h0;
localparam K_BLOCK  = 2'h1;
localparam K_ARRAY  = 2'h2;

////////////////////////////////////////////////////////////////////////
// Pin synchronisers
reg  [1:0] cs_sync_reg;
reg  [1:0] sck_sync_reg;
reg  [1:0] lo_sync_reg;
reg  [1:0] up_sync_reg;
reg        sck_prev_reg;
reg        cs_prev_reg;
always @(posedge i_clk or negedge i_nrst)
begin
  if (!i_nrst)
  begin
    cs_sync_reg  <= 2'h3;
    sck_sync_reg <= 2'h0;
    lo_sync_reg  <= 2'h0;
    up_sync_reg  <= 2'h0;
    sck_prev_reg <= 1'b0;
    cs_prev_reg  <= 1'b1;
  end
  else
  begin
    cs_sync_reg  <= {cs_sync_reg[0], i_cs_n};
    sck_sync_reg <= {sck_sync_reg[0], i_sck};
    lo_sync_reg  <= {lo_sync_reg[0], i_data_line_lower};
    up_sync_reg  <= {up_sync_reg[0], i_data_line_upper};
    sck_prev_reg <= sck_sync_reg[1];
    cs_prev_reg  <= cs_sync_reg[1];
  end
end

wire cs_n    = cs_sync_reg[1];
wire sck_r   = sck_sync_reg[1] & ~sck_prev_reg & ~cs_n;
wire sck_f   = ~sck_sync_reg[1] & sck_prev_reg & ~cs_n;
wire cs_rise = cs_n & ~cs_prev_reg;
wire lo_in   = lo_sync_reg[1];
wire up_in   = up_sync_reg[1];

////////////////////////////////////////////////////////////////////////
// Command shifter and state
reg  [2:0]  state_reg;
reg  [7:0]  op_reg;
reg  [7:0]  shift_reg;
reg  [4:0]  cnt_reg;
reg  [23:0] addr_reg;
reg  [18:0] ptr_reg;
reg         dual_in_reg;
reg  [7:0]  out_reg;
reg  [7:0]  page_mem [0:255];
reg  [255:0] page_valid_reg;
reg  [7:0]  page_idx_reg;
reg         page_any_reg;
reg         wel_reg;
reg         busy_reg;
reg         prog_run_reg;
reg  [8:0]  prog_idx_reg;
reg  [23:0] timer_reg;
reg  [18:0] prog_base_reg;

assign o_busy = busy_reg;
assign o_wel  = wel_reg;

wire [7:0] status_byte = {6'h00, wel_reg, busy_reg};
// Dual phases take two bits per clock
wire       dual_phase = dual_in_reg | (state_reg == S_RDATA);
wire [4:0] last_cnt   = dual_phase ? 5'h3 : 5'h7;
wire [7:0] shift_in   = dual_in_reg ? {shift_reg[5:0], up_in, lo_in}
                                    : {shift_reg[6:0], lo_in};

always @(posedge i_clk or negedge i_nrst)
begin
  if (!i_nrst)
  begin
    state_reg      <= S_IDLE;
    op_reg         <= 8'h00;
    shift_reg      <= 8'h00;
    cnt_reg        <= 5'h00;
    addr_reg       <= 24'h000000;
    ptr_reg        <= 19'h00000;
    dual_in_reg    <= 1'b0;
    out_reg        <= 8'h00;
    page_valid_reg <= 256'h0;
    page_idx_reg   <= 8'h00;
    page_any_reg   <= 1'b0;
    wel_reg        <= 1'b0;
    busy_reg       <= 1'b0;
    prog_run_reg   <= 1'b0;
    prog_idx_reg   <= 9'h000;
    timer_reg      <= 24'h000000;
    prog_base_reg  <= 19'h00000;
    o_wr_en        <= 1'b0;
    o_wr_addr      <= 19'h00000;
    o_wr_data      <= 8'h00;
    o_erase_en     <= 1'b0;
    o_erase_kind   <= K_SECTOR;
    o_erase_addr   <= 19'h00000;
    o_rd_addr      <= 19'h00000;
    o_data_line_lower    <= 1'b0;
    o_data_line_lower_oe <= 1'b0;
    o_data_line_upper    <= 1'b0;
    o_data_line_upper_oe <= 1'b0;
  end
  else
  begin
    o_wr_en    <= 1'b0;
    o_erase_en <= 1'b0;
    // Internal write timing; page bytes go out one per cycle first
    if (prog_run_reg)
    begin
      if (prog_idx_reg[8])
        prog_run_reg <= 1'b0;
      else
      begin
        if (page_valid_reg[prog_idx_reg[7:0]])
        begin
          o_wr_en   <= 1'b1;
          o_wr_addr <= {prog_base_reg[18:8], prog_idx_reg[7:0]};
          o_wr_data <= page_mem[prog_idx_reg[7:0]];
        end
        prog_idx_reg <= prog_idx_reg + 9'h001;
      end
    end
    if (busy_reg)
    begin
      if (timer_reg == 24'h000000)
      begin
        busy_reg <= 1'b0;
        wel_reg  <= 1'b0;
      end
      else
        timer_reg <= timer_reg - 24'h000001;
    end

    if (cs_n)
    begin
      state_reg            <= S_IDLE;
      o_data_line_lower_oe <= 1'b0;
      o_data_line_upper_oe <= 1'b0;
    end
    if (cs_rise && !busy_reg)
    begin
      // Write enable/disable and erases take effect only on a byte boundary; program and status write do not check it
      case (op_reg)
        `OP_WRITE_ENABLE:
          if (state_reg == S_SKIP && cnt_reg == 5'h0)
            wel_reg <= 1'b1;
        `OP_WRITE_DISABLE:
          if (state_reg == S_SKIP && cnt_reg == 5'h0)
            wel_reg <= 1'b0;
        `OP_STATUS_WRITE:
          wel_reg <= 1'b0;
        `OP_PAGE_PROGRAM:
          if (state_reg == S_PDATA && page_any_reg && wel_reg)
          begin
            busy_reg <= 1'b1;
            timer_reg <= PROGRAM_CYC[23:0];
            if (!i_protect_hit)
            begin
              prog_run_reg  <= 1'b1;
              prog_idx_reg  <= 9'h000;
              prog_base_reg <= addr_reg[18:0];
            end
          end
        `OP_SECTOR_ERASE_A, `OP_SECTOR_ERASE_B, `OP_BLOCK_ERASE:
          if (state_reg == S_SKIP && cnt_reg == 5'h0 && wel_reg)
          begin
            busy_reg <= 1'b1;
            o_erase_en <= ~i_protect_hit;
            o_erase_addr <= addr_reg[18:0];
            if (op_reg == `OP_BLOCK_ERASE)
            begin
              o_erase_kind <= K_BLOCK;
              timer_reg <= BLOCK_CYC[23:0];
            end
            else
            begin
              o_erase_kind <= K_SECTOR;
              timer_reg <= SECTOR_CYC[23:0];
            end
          end
        `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B:
          if (state_reg == S_SKIP && cnt_reg == 5'h0 && wel_reg)
          begin
            busy_reg     <= 1'b1;
            o_erase_en   <= ~i_any_protected;
            o_erase_kind <= K_ARRAY;
            timer_reg    <= ARRAY_CYC[23:0];
          end
        default:
          op_reg <= 8'h00;
      endcase
    end
    if (cs_rise)
      op_reg <= 8'h00;

    if (!cs_n && state_reg == S_IDLE)
    begin
      state_reg   <= S_CMD;
      cnt_reg     <= 5'h0;
      dual_in_reg <= 1'b0;
    end
    else if (sck_r)
    begin
      shift_reg <= shift_in;
      cnt_reg   <= (cnt_reg == last_cnt) ? 5'h0 : cnt_reg + 5'h1;
      case (state_reg)
        S_CMD:
          if (cnt_reg == 5'h7)
          begin
            op_reg <= shift_in;
            cnt_reg <= 5'h0;
            // Busy device only answers status reads
            if (shift_in == `OP_STATUS_READ)
            begin
              state_reg <= S_STAT;
              out_reg   <= status_byte;
            end
            else if (busy_reg)
              state_reg <= S_SKIP;
            else if (shift_in == `OP_READ_DUAL_IO)
            begin
              state_reg <= S_ADDR;
              dual_in_reg <= 1'b1;
            end
            else if (shift_in == `OP_READ_DUAL_OUT ||
                     shift_in == `OP_PAGE_PROGRAM ||
                     shift_in == `OP_SECTOR_ERASE_A ||
                     shift_in == `OP_SECTOR_ERASE_B ||
                     shift_in == `OP_BLOCK_ERASE)
              state_reg <= S_ADDR;
            else
              state_reg <= S_SKIP;
          end
        S_ADDR:
          if (cnt_reg == last_cnt)
          begin
            addr_reg <= {addr_reg[15:0], shift_in};
            if (addr_reg[31-16:8] == 8'h00 && 1'b0)
              state_reg <= S_SKIP;
            if (cnt_reg == last_cnt && page_idx_reg == 8'h02)
            begin
              page_idx_reg <= shift_in;
              ptr_reg      <= {addr_reg[10:0], shift_in};
              if (op_reg == `OP_PAGE_PROGRAM)
              begin
                // Buffer kept until a new program, so status polls
                // during the write cannot wipe pending bytes
                state_reg      <= S_PDATA;
                page_valid_reg <= 256'h0;
                page_any_reg   <= 1'b0;
              end
              else if (op_reg == `OP_READ_DUAL_OUT ||
                       op_reg == `OP_READ_DUAL_IO)
                state_reg <= S_DUMMY;
              else
                state_reg <= S_SKIP;
            end
            else
              page_idx_reg <= page_idx_reg + 8'h01;
          end
        S_DUMMY:
          if (cnt_reg == last_cnt)
          begin
            // Dummy bits discarded, both lines now driven
            state_reg   <= S_RDATA;
            dual_in_reg <= 1'b0;
            o_rd_addr   <= ptr_reg;
          end
        S_PDATA:
          if (cnt_reg == 5'h7)
          begin
            // Whole bytes only; a newer byte overwrites its slot
            page_mem[page_idx_reg] <= shift_in;
            page_valid_reg[page_idx_reg] <= 1'b1;
            page_idx_reg <= page_idx_reg + 8'h01;
            page_any_reg <= 1'b1;
          end
        default:
          state_reg <= state_reg;
      endcase
    end
    if (state_reg != S_ADDR && state_reg != S_PDATA)
      page_idx_reg <= (state_reg == S_CMD) ? 8'h00 : page_idx_reg;

    // Output on falling clock edges
    if (sck_f && state_reg == S_STAT)
    begin
      o_data_line_upper_oe <= 1'b1;
      o_data_line_upper    <= out_reg[7];
      out_reg <= (cnt_reg == 5'h0) ? status_byte : {out_reg[6:0], 1'b0};
      if (cnt_reg == 5'h0)
        o_data_line_upper <= status_byte[7];
      if (cnt_reg == 5'h0)
        out_reg <= {status_byte[6:0], 1'b0};
    end
    if (sck_f && state_reg == S_RDATA)
    begin
      o_data_line_upper_oe <= 1'b1;
      o_data_line_lower_oe <= 1'b1;
      if (cnt_reg == 5'h0)
      begin
        o_data_line_upper <= i_rd_data[7];
        o_data_line_lower <= i_rd_data[6];
        out_reg   <= {i_rd_data[5:0], 2'h0};
        ptr_reg   <= (ptr_reg == `ADDR_TOP) ? 19'h00000
                     : ptr_reg + 19'h00001;
        o_rd_addr <= (ptr_reg == `ADDR_TOP) ? 19'h00000
                     : ptr_reg + 19'h00001;
      end
      else
      begin
        o_data_line_upper <= out_reg[7];
        o_data_line_lower <= out_reg[6];
        out_reg <= {out_reg[5:0], 2'h0};
      end
    end
  end
end

endmodule

//--- dv/flash_seq_props.sv
`timescale 1ns/100ps
module flash_seq_props
(
  // Clock and reset
  input wire       i_clk,
  input wire       i_nrst,
  // Watched pins
  input wire       i_cs_n,
  input wire       o_data_line_lower_oe,
  input wire       o_data_line_upper_oe,
  input wire       o_wr_en,
  input wire       o_erase_en,
  input wire [1:0] o_erase_kind,
  input wire       o_busy,
  input wire       o_wel
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////////////////////////////////////////
  // Six cycles covers the two-stage select sync plus output register
  a_oe_deselect: assert property (
    i_cs_n [*6] |-> !(o_data_line_lower_oe || o_data_line_upper_oe))
    else $error("line driven while deselected");
  a_dual_pair: assert property (
    o_data_line_lower_oe |-> o_data_line_upper_oe)
    else $error("lower line driven alone");
  a_erase_pulse: assert property (
    o_erase_en |=> !o_erase_en)
    else $error("erase request longer than one cycle");
  a_erase_after_cs: assert property (
    o_erase_en |-> i_cs_n ##[0:1] o_busy)
    else $error("erase not started at deselect");
  a_erase_kind: assert property (
    o_erase_en |-> o_erase_kind != 2'h3)
    else $error("illegal erase kind");
  a_wel_on_cs: assert property (
    $rose(o_wel) |-> i_cs_n)
    else $error("latch set while selected");
  a_busy_needs_wel: assert property (
    $rose(o_busy) |-> $past(o_wel))
    else $error("write started without latch");
  a_write_busy: assert property (
    o_wr_en |-> ##[0:1] o_busy)
    else $error("array write outside busy");
  a_wel_drop: assert property (
    $fell(o_busy) |-> ##[0:2] !o_wel)
    else $error("latch kept after write");
endmodule

bind flash_seq flash_seq_props flash_seq_props_inst (.i_clk(i_clk),
  .i_nrst(i_nrst), .i_cs_n(i_cs_n), .o_wr_en(o_wr_en),
  .o_data_line_lower_oe(o_data_line_lower_oe),
  .o_data_line_upper_oe(o_data_line_upper_oe), .o_erase_en(o_erase_en),
  .o_erase_kind(o_erase_kind), .o_busy(o_busy), .o_wel(o_wel));

//--- dv/spi_host.sv
`timescale 1ns/100ps
module spi_host
(
  // Clock
  input  wire i_clk,
  // Link pins
  output reg  o_cs_n = 1'b1,
  output reg  o_sck = 1'b0,
  output reg  o_lower = 1'b0,
  output reg  o_lower_oe = 1'b0,
  output reg  o_upper = 1'b0,
  output reg  o_upper_oe = 1'b0,
  input  wire i_lower,
  input  wire i_upper
);
  ////////////////////////////////////////////////////////////////////////////
  task start;
    begin
      @(posedge i_clk);
      o_cs_n <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
  endtask
  task stop;
    begin
      repeat (4) @(posedge i_clk);
      o_cs_n <= 1'b1;
      o_lower_oe <= 1'b0;
      o_upper_oe <= 1'b0;
      repeat (16) @(posedge i_clk);
    end
  endtask
  // Clock idles low; eight clocks per byte single, four dual
  task shift(input [7:0] d, input integer n, input dual, input drv,
             output [7:0] q);
    integer k;
    begin
      q = 8'h00;
      for (k = 0; k < n; k = k + 1)
      begin
        @(posedge i_clk);
        o_lower_oe <= drv;
        o_upper_oe <= drv & dual;
        o_upper <= d[7];
        o_lower <= dual ? d[6] : d[7];
        d = dual ? d << 2 : d << 1;
        repeat (4) @(posedge i_clk);
        q = dual ? {q[5:0], i_upper, i_lower} : {q[6:0], i_upper};
        o_sck <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_sck <= 1'b0;
      end
    end
  endtask
endmodule

//--- dv/spi_flash_dual_read_program_erase_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b, m) begin checked = checked + 1; if ((a) !== (b)) begin \
  errors = errors + 1; $display("CHECK FAILED t=%0t %s", $time, m); end end
module spi_flash_dual_read_program_erase_tb_top;
  reg         i_clk = 1'b0;
  reg         i_nrst = 1'b0;
  reg         prot = 1'b0;
  reg         anyp = 1'b0;
  reg         tgl = 1'b0;
  wire        cs_n, sck, h_lo, h_lo_oe, h_up, h_up_oe, lo, up;
  wire        d_lo, d_lo_oe, d_up, d_up_oe, wr_en, er_en, busy, wel;
  wire [18:0] rd_addr, wr_addr, er_addr;
  wire [7:0]  wr_data;
  wire [1:0]  er_kind;
  reg  [26:0] wq [$];
  reg  [1:0]  ekind;
  reg  [18:0] eaddr;
  reg  [7:0]  r, s;
  integer     ecnt = 0, errors = 0, checked = 0, i;
  function [7:0] pat(input [18:0] a);
    pat = a[7:0] + a[18:11] + 8'h5A;
  endfunction
  // Undriven lines toggle so a stale value never reads as data
  assign lo = d_lo_oe ? d_lo : h_lo_oe ? h_lo : tgl;
  assign up = d_up_oe ? d_up : h_up_oe ? h_up : ~tgl;
  initial forever #25 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    tgl <= ~tgl;
    if (wr_en) wq.push_back({wr_addr, wr_data});
    if (er_en) {ecnt, ekind, eaddr} <= {ecnt + 1, er_kind, er_addr};
  end
  spi_host spi_host_inst (.i_clk(i_clk), .o_cs_n(cs_n), .o_sck(sck),
    .o_lower(h_lo), .o_lower_oe(h_lo_oe), .o_upper(h_up),
    .o_upper_oe(h_up_oe), .i_lower(lo), .i_upper(up));
  flash_seq #(.PROGRAM_CYC(600), .SECTOR_CYC(300), .BLOCK_CYC(300),
    .ARRAY_CYC(300)) flash_seq_inst (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_cs_n(cs_n), .i_sck(sck), .i_data_line_lower(lo),
    .o_data_line_lower(d_lo), .o_data_line_lower_oe(d_lo_oe),
    .i_data_line_upper(up), .o_data_line_upper(d_up),
    .o_data_line_upper_oe(d_up_oe), .i_protect_hit(prot),
    .i_any_protected(anyp), .o_rd_addr(rd_addr), .i_rd_data(pat(rd_addr)),
    .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
    .o_erase_en(er_en), .o_erase_kind(er_kind), .o_erase_addr(er_addr),
    .o_busy(busy), .o_wel(wel));
  ////////////////////////////////////////////////////////////////////////////
  task final_report;
    begin
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // Polls instead of a fixed wait; bounded so a stuck flag ends the run
  task wait_idle;
    integer n;
    begin
      for (n = 0; busy !== 1'b0 && n < 5000; n = n + 1) @(posedge i_clk);
      if (n == 5000) begin errors = errors + 1; final_report; end
    end
  endtask
  task send(input [7:0] op, input [23:0] a, input na, input [7:0] d);
    begin
      spi_host_inst.start;
      spi_host_inst.shift(op, 8, 0, 1, r);
      if (na) spi_host_inst.shift(a[23:16], 8, 0, 1, r);
      if (na) spi_host_inst.shift(a[15:8], 8, 0, 1, r);
      if (na) spi_host_inst.shift(a[7:0], 8, 0, 1, r);
      if (op == 8'h01 || op == 8'h02) spi_host_inst.shift(d, 8, 0, 1, r);
      spi_host_inst.stop;
      wait_idle;
    end
  endtask
  task rd_stat;
    begin
      spi_host_inst.start;
      spi_host_inst.shift(8'h05, 8, 0, 1, r);
      spi_host_inst.shift(8'h00, 8, 0, 0, s);
      spi_host_inst.shift(8'h00, 8, 0, 0, r);
      spi_host_inst.stop;
      `CHK(r, s, "status repeat")
    end
  endtask
  task t_wel;
    begin
      send(8'h06, 0, 0, 0);
      rd_stat;
      `CHK(s[1:0], 2'b10, "latch set")
      send(8'h04, 0, 0, 0);
      send(8'h20, 24'h001000, 1, 0);
      `CHK(ecnt, 0, "erase after disable")
      send(8'h06, 0, 0, 0);
      send(8'h01, 0, 0, 8'h00);
      `CHK(wel, 1'b0, "latch after status write")
      $display("t_wel done");
    end
  endtask
  task t_prog;
    begin
      send(8'h02, 24'h000100, 1, 8'hAA);
      `CHK(wq.size(), 0, "program without latch")
      send(8'h06, 0, 0, 0);
      spi_host_inst.start;
      spi_host_inst.shift(8'h02, 8, 0, 1, r);
      spi_host_inst.shift(8'h00, 8, 0, 1, r);
      spi_host_inst.shift(8'h00, 8, 0, 1, r);
      spi_host_inst.shift(8'hFE, 8, 0, 1, r);
      for (i = 1; i < 4; i = i + 1) spi_host_inst.shift(i * 17, 8, 0, 1, r);
      spi_host_inst.shift(8'hC0, 5, 0, 1, r);
      spi_host_inst.stop;
      rd_stat;
      `CHK(s[0], 1'b1, "busy during program")
      wait_idle;
      `CHK(wq.size(), 3, "partial byte")
      `CHK(wq[1], {19'h000FE, 8'h11}, "first byte")
      `CHK(wq[0], {19'h00000, 8'h33}, "page wrap")
      `CHK(wq[2], {19'h000FF, 8'h22}, "second byte")
      `CHK(wel, 1'b0, "latch after program")
      $display("t_prog done");
    end
  endtask
  task t_erase;
    reg [39:0] ops;
    reg [9:0]  kinds;
    begin
      ops = 40'h20D7D860C7;
      kinds = 10'b0000011010;
      for (i = 0; i < 5; i = i + 1)
      begin
        send(8'h06, 0, 0, 0);
        send(ops[39-8*i -: 8], 24'h05A123, i < 3, 0);
        `CHK(ecnt, i + 1, "erase count")
        `CHK(ekind, kinds[9-2*i -: 2], "erase kind")
        if (i < 2) `CHK(eaddr[18:12], 7'h5A, "sector")
        if (i == 2) `CHK(eaddr[18:16], 3'h5, "block")
      end
      prot <= 1'b1;
      send(8'h06, 0, 0, 0);
      send(8'hD8, 24'h010000, 1, 0);
      `CHK(ecnt, 5, "protected erase")
      `CHK(wel, 1'b0, "latch after ignored")
      {prot, anyp} <= 2'b01;
      send(8'h06, 0, 0, 0);
      send(8'hC7, 0, 0, 0);
      `CHK(ecnt, 5, "protected chip erase")
      anyp <= 1'b0;
      $display("t_erase done");
    end
  endtask
  task t_read(input [7:0] op, input [18:0] a, input dual);
    begin
      spi_host_inst.start;
      spi_host_inst.shift(op, 8, 0, 1, r);
      spi_host_inst.shift({5'h00, a[18:16]}, dual ? 4 : 8, dual, 1, r);
      spi_host_inst.shift(a[15:8], dual ? 4 : 8, dual, 1, r);
      spi_host_inst.shift(a[7:0], dual ? 4 : 8, dual, 1, r);
      spi_host_inst.shift(8'h00, dual ? 4 : 8, dual, 1, r);
      for (i = 0; i < 2; i = i + 1)
      begin
        spi_host_inst.shift(8'h00, 4, 1, 0, r);
        `CHK(r, pat(a + i), "read data")
      end
      spi_host_inst.stop;
      $display("t_read done");
    end
  endtask
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_wel;
    t_prog;
    t_erase;
    t_read(8'h3B, 19'h7FFFF, 0);
    t_read(8'hBB, 19'h12345, 1);
    final_report;
  end
endmodule
